// ### dpm_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpm_cfg.svh"

module dpm_regs
   import dpm_pkg::*;
(
   input  wire logic                    i_clk,          // Control clock
   input  wire logic                    i_resetn,       // Sync reset, active low
   input  wire dpm_req_t                i_req,          // Host register request
   input  wire logic [`DPM_VOL_W-1:0]   i_vol_code,     // Volume code to convert
   output var  dpm_rsp_t                o_rsp,          // Read answer, one cycle later
   output var  dpm_mode_t               o_mode [`DPM_NUM_CH], // Per-channel power mode
   output var  logic [`DPM_ATTEN_W-1:0] o_atten_mdb     // Attenuation in millidecibels
);

   // Index value that marks an offset outside the bank
   localparam logic [1:0]   NO_REG = 2'h3;

   // Power adjust registers, one byte each
   logic [7:0]              pwr_r    [`DPM_NUM_REGS];
   logic [7:0]              pwr_nxt  [`DPM_NUM_REGS];

   // Read answer
   dpm_rsp_t                rsp_r;
   dpm_rsp_t                rsp_nxt;

   // Decoded per-channel modes
   dpm_mode_t               mode_r   [`DPM_NUM_CH];
   dpm_mode_t               mode_nxt [`DPM_NUM_CH];

   // Volume attenuation
   logic [`DPM_ATTEN_W-1:0] atten_r;
   logic [`DPM_ATTEN_W-1:0] atten_nxt;

   // Shared decode of the request
   logic [1:0]              req_idx;
   logic                    req_hit;
   logic                    wr_take;
   logic                    rd_take;

   // Map an offset to a register index; NO_REG means unmapped
   function automatic logic [1:0] reg_index(input logic [7:0] addr);
      unique case (addr)
         `DPM_OFS_PWR1: reg_index = 2'h0;
         `DPM_OFS_PWR2: reg_index = 2'h1;
         `DPM_OFS_PWR3: reg_index = 2'h2;
         default:       reg_index = NO_REG;
      endcase
   endfunction

   // Register that holds a given channel, counted from zero
   function automatic int reg_of_chan(input int chan);
      reg_of_chan = chan / `DPM_CH_PER_REG;
   endfunction

   // Field slot of a channel inside its register, lowest channel lowest
   function automatic int slot_of_chan(input int chan);
      slot_of_chan = chan % `DPM_CH_PER_REG;
   endfunction

   // Two-bit field of one slot
   function automatic logic [1:0] field_of(input logic [7:0] reg_val,
                                           input int         slot);
      field_of = reg_val[slot * `DPM_FIELD_W +: `DPM_FIELD_W];
   endfunction

   // Linear in code: no table needed, and 255 steps still fit the width
   function automatic logic [`DPM_ATTEN_W-1:0] atten_of(input logic [`DPM_VOL_W-1:0] code);
      atten_of = `DPM_ATTEN_W'(code) * `DPM_ATTEN_W'(`DPM_VOL_STEP_MDB);
   endfunction

   // Request decode
   always_comb begin
      req_idx = reg_index(i_req.addr);
      req_hit = (req_idx != NO_REG);
      wr_take = i_req.wr && req_hit;
      rd_take = i_req.rd;
   end

   // Power adjust registers: next value
   always_comb begin
      for (int r = 0; r < `DPM_NUM_REGS; r++) begin
         pwr_nxt[r] = pwr_r[r];
      end
      // Writes to unmapped offsets are dropped
      if (wr_take) begin
         pwr_nxt[req_idx] = i_req.wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         for (int r = 0; r < `DPM_NUM_REGS; r++) begin
            pwr_r[r] <= `DPM_PWR_RESET;
         end
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // Read answer: next value
   always_comb begin
      rsp_nxt = '0;
      if (rd_take) begin
         rsp_nxt.valid = 1'b1;
         rsp_nxt.hit   = req_hit;
         // Old value on a same-cycle write; unmapped offsets read as zero
         if (req_hit) begin
            rsp_nxt.rdata = pwr_r[req_idx];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rsp_r <= '0;
      end else begin
         rsp_r <= rsp_nxt;
      end
   end

   // Channel modes follow the registers in the same edge as the write
   always_comb begin
      for (int c = 0; c < `DPM_NUM_CH; c++) begin
         mode_nxt[c] = dpm_mode_t'(field_of(pwr_nxt[reg_of_chan(c)],
                                            slot_of_chan(c)));
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         for (int c = 0; c < `DPM_NUM_CH; c++) begin
            mode_r[c] <= dpm_mode_t'(`DPM_FIELD_RESET);
         end
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Attenuation: next value
   always_comb begin
      atten_nxt = atten_of(i_vol_code);
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         atten_r <= '0;
      end else begin
         atten_r <= atten_nxt;
      end
   end

   assign o_rsp       = rsp_r;
   assign o_mode      = mode_r;
   assign o_atten_mdb = atten_r;

endmodule
`default_nettype wire

// ### dpm_cfg.svh
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH

// Register offsets on the control port, reset values and channel field layout
`define DPM_OFS_PWR1       8'h1D
`define DPM_OFS_PWR2       8'h1E
`define DPM_OFS_PWR3       8'h1F
`define DPM_PWR_RESET      8'hAA
`define DPM_FIELD_RESET    2'h2
`define DPM_FIELD_W        2
`define DPM_NUM_CH         12
`define DPM_CH_PER_REG     4
`define DPM_NUM_REGS       3
// Volume step in millidecibels
`define DPM_VOL_STEP_MDB   375
`define DPM_VOL_W          8
`define DPM_ATTEN_W        17

`endif

// ### dpm_pkg.sv
`default_nettype none
`include "dpm_cfg.svh"
package dpm_pkg;
   typedef enum logic [1:0] {
      DPM_LOW_POWER,
      DPM_LOWEST_POWER,
      DPM_BEST_PERF,
      DPM_GOOD_PERF
   } dpm_mode_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpm_req_t;

   typedef struct packed {
      logic       valid;
      logic       hit;
      logic [7:0] rdata;
   } dpm_rsp_t;
endpackage
`default_nettype wire

// ### dpm_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dpm_regs_monitor import dpm_pkg::*; (
   input wire logic i_clk, input wire logic i_resetn, input wire dpm_req_t i_req,
   input wire logic [7:0] i_vol_code, input wire dpm_rsp_t o_rsp,
   input wire dpm_mode_t o_mode [12], input wire logic [16:0] o_atten_mdb);
   wire r = i_req.rd, w = i_req.wr;
   wire [7:0] a = i_req.addr, d = i_req.wdata;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   a_rd_answer: assert property (r |=> o_rsp.valid) else $error("r");
   a_no_stray: assert property (!r |=> !o_rsp.valid) else $error("s");
   a_ch4_wr: assert property (w && a == 8'h1D |=> o_mode[3] == $past(d[7:6])) else $error("m");
   a_ch5_wr: assert property (w && a == 8'h1E |=> o_mode[4] == $past(d[1:0])) else $error("m");
   a_ch12_wr: assert property (w && a == 8'h1F |=> o_mode[11] == $past(d[7:6])) else $error("m");
   a_read_back: assert property (r && !w && a == 8'h1E |=> o_rsp.hit &&
      o_rsp.rdata == {o_mode[7], o_mode[6], o_mode[5], o_mode[4]}) else $error("b");
   a_reset_best: assert property ($rose(i_resetn) |-> o_mode[0] == DPM_BEST_PERF) else $error("x");
   a_vol_step: assert property (1 |=> o_atten_mdb == $past(i_vol_code) * 17'h177) else $error("v");
   cover property (w && a == 8'h1E);
   cover property (r ##1 !o_rsp.hit);
   cover property (i_vol_code == 8'h30);
endmodule
bind dpm_regs dpm_regs_monitor u_mon (.i_clk, .i_resetn, .i_req, .i_vol_code, .o_rsp, .o_mode,
   .o_atten_mdb);
`default_nettype wire

// ### dpm_host.sv
`timescale 1ns/1ns
`default_nettype none
module dpm_host import dpm_pkg::*; (
   input  wire logic     i_clk, // Control clock
   output var  dpm_req_t o_req  // Request to the register bank
);
   initial o_req = '0;
   // Strobe drops after one taken edge, so each call is exactly one access
   task automatic acc(input logic wr, input logic [7:0] ad, input logic [7:0] dt);
      @(negedge i_clk) o_req <= '{wr, !wr, ad, dt};
      @(negedge i_clk) o_req <= '0;
   endtask
endmodule
`default_nettype wire

// ### tb_dac_power_mode_volume_regs.sv
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_dac_power_mode_volume_regs import dpm_pkg::*;;
   logic clk = 0, rstn = 0;
   logic [7:0] vol = 8'h00;
   logic [16:0] att;
   dpm_req_t req;
   dpm_rsp_t rsp;
   dpm_mode_t mode [12];
   int miscompares = 0, tests_run = 0, cyc = 0, b;
   // Offset then data; every field code appears
   logic [15:0] rows [4] = '{16'h1D1B, 16'h1EE4, 16'h1F55, 16'h1DFF};
   always #2 clk = ~clk;
   dpm_host u_host (.i_clk(clk), .o_req(req));
   dpm_regs u_dut (.i_clk(clk), .i_resetn(rstn), .i_req(req), .i_vol_code(vol), .o_rsp(rsp),
      .o_mode(mode), .o_atten_mdb(att));
   task print_verdict;
      if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) if (++cyc > 400) begin miscompares++; print_verdict; end
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1;
      for (int i = 0; i < 3; i++) begin
         u_host.acc(0, 8'h1D + 8'(i), 8'h00);
         `CK("reset", 9'h1AA, {rsp.hit, rsp.rdata})
      end
      foreach (rows[i]) begin
         b = (rows[i][15:8] - 8'h1D) * 4;
         u_host.acc(1, rows[i][15:8], rows[i][7:0]);
         `CK("field", rows[i][7:6], mode[b + 3])
         `CK("field_lo", rows[i][1:0], mode[b])
         u_host.acc(0, rows[i][15:8], 8'h00);
         `CK("read", rows[i][7:0], rsp.rdata)
         `CK("valid", 1'b1, rsp.valid)
      end
      u_host.acc(0, 8'h1C, 8'h00);
      `CK("unmapped", 9'h000, {rsp.hit, rsp.rdata})
      vol = 8'h30;
      @(negedge clk) `CK("atten", 17'h0_4650, att)
      rstn = 0;
      @(negedge clk) rstn = 1;
      `CK("mode", DPM_BEST_PERF, mode[11])
      print_verdict;
   end
endmodule
`default_nettype wire
